/* File: init_model.sv */
// initiator model that takes message-in bytes from the target
`timescale 1ns/1ps
`default_nettype none
module init_model (
	input  wire logic       clk_in,
	input  wire logic       valid_in,
	input  wire logic [7:0] byte_in,
	input  wire logic [3:0] delay_in,   // handshake stall in cycles
	output logic            ready_out,
	output logic            took_out,   // one-cycle flag: byte_out is new
	output logic      [7:0] byte_out
);
	// ----------------------------------------
	// receive side handshake
	// ----------------------------------------
	// any byte accepted
	// reject and identify are taken like any byte; attention is not modelled,
	// so this initiator never refuses and never reports parity faults
	initial begin
		ready_out = 1'b0;
		took_out = 1'b0;
		byte_out = 8'h00;
		forever begin
			@(posedge clk_in);
			#1;
			took_out = 1'b0;
			if (valid_in === 1'b1) begin
				repeat (delay_in) @(posedge clk_in);
				#1;
				byte_out = byte_in;
				ready_out = 1'b1;
				@(posedge clk_in);
				#1;
				ready_out = 1'b0;
				took_out = 1'b1;
			end
		end
	end
endmodule // init_model
`default_nettype wire

/* File: msg_pkg.sv */
// constants for the target message handler
package msg_pkg;
	// message codes
	localparam logic [7:0] MSG_CMD_DONE   = 8'h00;
	localparam logic [7:0] MSG_EXTENDED   = 8'h01;
	localparam logic [7:0] MSG_SAVE_PTR   = 8'h02;
	localparam logic [7:0] MSG_DISCONNECT = 8'h04;
	localparam logic [7:0] MSG_INIT_ERR   = 8'h05;
	localparam logic [7:0] MSG_ABORT      = 8'h06;
	localparam logic [7:0] MSG_REJECT     = 8'h07;
	localparam logic [7:0] MSG_NOP        = 8'h08;
	localparam logic [7:0] MSG_PARITY     = 8'h09;
	localparam logic [7:0] MSG_LINKED     = 8'h0A;
	localparam logic [7:0] MSG_LINKED_FLG = 8'h0B;
	localparam logic [7:0] MSG_BDR        = 8'h0C;
	localparam logic [7:0] MSG_IDENTIFY   = 8'h80;
	localparam logic [7:0] EXT_LEN        = 8'h03;
	localparam logic [7:0] EXT_SYNC_CODE  = 8'h01;
	// identify fields
	localparam int ID_BIT      = 7;
	localparam int ID_DISC_BIT = 6;
	// period band upper limits, in 4 ns units
	localparam logic [7:0] BAND_0 = 8'h3E;
	localparam logic [7:0] BAND_1 = 8'h5D;
	localparam logic [7:0] BAND_2 = 8'h7D;
	localparam logic [7:0] BAND_3 = 8'h9C;
	localparam logic [7:0] BAND_4 = 8'hBB;
	localparam logic [7:0] BAND_5 = 8'hDA;
	localparam logic [7:0] BAND_6 = 8'hFA;
	localparam int PERIOD_UNIT_NS = 4;
	localparam logic [7:0] MIN_PERIOD = 8'h3E;
	localparam logic [3:0] MAX_OFFSET = 4'h8;
	// sense data
	localparam logic [3:0] SK_ABORTED    = 4'hB;
	localparam logic [7:0] ASC_INIT_ERR  = 8'h48;
	localparam logic [7:0] ASC_REJECT    = 8'h43;
	localparam logic [7:0] ASC_PARITY    = 8'h47;
	localparam logic [3:0] RESET_OFFSET  = 4'h0;
	localparam logic [7:0] RESET_PERIOD  = 8'h00;
	localparam int NUM_INITIATORS        = 8;
endpackage

/* File: scsi_msg_handler.sv */
// message phase handler of a parallel bus disk target
`timescale 1ns/1ps
`default_nettype none
// Function
// RQ1: map period byte to one of eight rates
// RQ2: originate sync request with safe offset
// RQ3: agreement holds until reset or renegotiation
// RQ4: initiator avoids renegotiating each selection
// RQ5: asynchronous at power-on and resets
// RQ6: negotiate only after selection with both ids
// RQ7: send save pointer before data disconnect
// RQ8: send disconnect before releasing busy
// RQ9: initiator flags unexpected bus free
// RQ10: initiator error ends with check condition
// RQ11: abort clears own initiator, bus free
// RQ12: send reject; take reject of ours
// RQ13: initiator raises attention before rejecting
// RQ14: reject sent before further message bytes
// RQ15: initiator with attention handles reject
// RQ16: no operation takes no action
// RQ17: initiator raises attention for parity error
// RQ18: linked complete 0A, or 0B with flag
// RQ19: bus device reset clears all, bus free
// RQ20: identify bit7 set, reserved zero, lun zero
// RQ21: only initiator sets disconnect bit
// RQ22: initiator restores pointers on reconnect identify
// RQ23: period byte counts 4 ns units
// RQ24: offset at most 8, zero is async
// RQ25: keep agreement per initiator
module scsi_msg_handler #(
	parameter int ID_W = 3
) (
	input  wire logic            CLK_SYS_IN,
	input  wire logic            RESETN_IN,
	input  wire logic            HARD_RESET_IN,     // bus reset, pin
	input  wire logic            SEL_BOTH_IDS_IN,   // selection carried both ids
	input  wire logic [ID_W-1:0] INIT_ID_IN,
	input  wire logic            MSG_OUT_VALID_IN,  // received message byte strobe
	input  wire logic [7:0]      MSG_OUT_BYTE_IN,
	input  wire logic            REQ_SAVE_DISC_IN,  // core asks to disconnect in data
	input  wire logic            REQ_DISC_IN,       // core asks to disconnect
	input  wire logic            REQ_LINKED_IN,
	input  wire logic            LINK_FLAG_IN,
	input  wire logic            REQ_RECONNECT_IN,
	input  wire logic            REQ_NEGOTIATE_IN,
	input  wire logic            MSG_IN_READY_IN,   // bus side took the byte
	output logic                 MSG_IN_VALID_OUT,
	output logic      [7:0]      MSG_IN_BYTE_OUT,
	output logic                 BUS_FREE_OUT,      // pulse: release busy
	output logic                 CHECK_COND_OUT,    // pulse: end with check condition
	output logic      [3:0]      SENSE_KEY_OUT,
	output logic      [7:0]      SENSE_CODE_OUT,
	output logic                 CLEAR_OWN_OUT,     // pulse: drop this initiator's work
	output logic                 CLEAR_ALL_OUT,     // pulse: drop all work
	output logic                 DISC_ALLOWED_OUT,
	output logic                 REJECTED_OUT,      // pulse: our last message refused
	output logic      [2:0]      RATE_SEL_OUT,      // 0 = 4.00 MHz .. 7 = 0.89 MHz
	output logic      [7:0]      SYNC_PERIOD_OUT,
	output logic      [3:0]      SYNC_OFFSET_OUT
);
	typedef enum {ST_IDLE, ST_EXT1, ST_EXT2, ST_EXT3, ST_EXT4} rx_t;
	rx_t rx_state;
	logic hr_s1;
	logic hr_s2;
	logic [7:0] req_period;
	logic [7:0] last_sent;
	logic send_busy;
	logic [2:0] send_cnt;
	logic [2:0] send_len;
	logic [7:0] send_buf [5];
	logic after_send_free;

	//----------------------------------------
	// bus reset synchroniser
	//----------------------------------------
	// hard reset arrives from a pin
	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			hr_s1 <= 1'b0;
			hr_s2 <= 1'b0;
		end else begin
			hr_s1 <= HARD_RESET_IN;
			hr_s2 <= hr_s1;
		end
	end

	//----------------------------------------
	// decode
	//----------------------------------------
	// RQ1 period band decode
	function automatic logic [2:0] rate_of(input logic [7:0] p);
		if (p <= msg_pkg::BAND_0) return 3'd0;
		else if (p <= msg_pkg::BAND_1) return 3'd1;
		else if (p <= msg_pkg::BAND_2) return 3'd2;
		else if (p <= msg_pkg::BAND_3) return 3'd3;
		else if (p <= msg_pkg::BAND_4) return 3'd4;
		else if (p <= msg_pkg::BAND_5) return 3'd5;
		else if (p <= msg_pkg::BAND_6) return 3'd6;
		else return 3'd7;
	endfunction

	wire rx = MSG_OUT_VALID_IN && !send_busy;
	wire [7:0] b = MSG_OUT_BYTE_IN;
	wire rx_idle = rx && (rx_state == ST_IDLE);
	// RQ20 identify validity
	wire is_ident = b[msg_pkg::ID_BIT];
	wire ident_ok = is_ident && (b[5:0] == 6'h00);
	wire got_bdr = rx_idle && (b == msg_pkg::MSG_BDR);
	wire got_abort = rx_idle && (b == msg_pkg::MSG_ABORT);
	wire got_ierr = rx_idle && (b == msg_pkg::MSG_INIT_ERR);
	wire got_parity = rx_idle && (b == msg_pkg::MSG_PARITY);
	wire got_reject = rx_idle && (b == msg_pkg::MSG_REJECT);
	// RQ16 no operation is simply accepted
	wire got_nop = rx_idle && (b == msg_pkg::MSG_NOP);
	wire got_ext = rx_idle && (b == msg_pkg::MSG_EXTENDED);
	wire got_ident = rx_idle && ident_ok;
	wire got_bad = rx_idle && !(got_bdr || got_abort || got_ierr || got_parity
		|| got_reject || got_nop || got_ext || got_ident);
	wire ext_fin = rx && (rx_state == ST_EXT4);
	wire ext_bad = rx && ((rx_state == ST_EXT1 && b != msg_pkg::EXT_LEN)
		|| (rx_state == ST_EXT2 && b != msg_pkg::EXT_SYNC_CODE)
		|| (rx_state == ST_EXT2 && !SEL_BOTH_IDS_IN));
	// RQ23 RQ24 answer: period no shorter, offset clipped to 8
	wire [7:0] ans_period = (req_period < msg_pkg::MIN_PERIOD) ? msg_pkg::MIN_PERIOD
		: req_period;
	wire [3:0] ans_offset = (b > 8'(msg_pkg::MAX_OFFSET)) ? msg_pkg::MAX_OFFSET : b[3:0];
	wire [11:0] tbl_q;
	// RQ5 RQ19 asynchronous after any reset event
	wire clr_all = hr_s2 || got_bdr;

	//----------------------------------------
	// receive state machine
	//----------------------------------------
	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			rx_state <= ST_IDLE;
			req_period <= msg_pkg::RESET_PERIOD;
		end else if (hr_s2 || ext_bad) begin
			rx_state <= ST_IDLE;
		end else if (rx) begin
			case (rx_state)
				ST_IDLE: rx_state <= got_ext ? ST_EXT1 : ST_IDLE;
				ST_EXT1: rx_state <= ST_EXT2;
				ST_EXT2: rx_state <= ST_EXT3;
				ST_EXT3: begin
					req_period <= b;
					rx_state <= ST_EXT4;
				end
				ST_EXT4: rx_state <= ST_IDLE;
				default: rx_state <= ST_IDLE;
			endcase
		end
	end

	//----------------------------------------
	// per-initiator agreement store
	//----------------------------------------
	// RQ3 RQ25 agreement kept until reset or new exchange
	sync_table #(.DEPTH(msg_pkg::NUM_INITIATORS), .AW(ID_W)) u_tbl (
		.clk_in    (CLK_SYS_IN),
		.resetn_in (RESETN_IN),
		.clear_in  (clr_all),
		.wr_in     (ext_fin),
		.waddr_in  (INIT_ID_IN),
		.wdata_in  ({ans_period, ans_offset}),
		.raddr_in  (INIT_ID_IN),
		.rdata_out (tbl_q)
	);

	// RQ24 zero offset selects asynchronous
	assign SYNC_PERIOD_OUT = tbl_q[11:4];
	assign SYNC_OFFSET_OUT = tbl_q[3:0];
	assign RATE_SEL_OUT = rate_of(tbl_q[11:4]);

	//----------------------------------------
	// outgoing message sequencer
	//----------------------------------------
	// reject first, over any pending core request
	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			send_busy <= 1'b0;
			send_cnt <= 3'd0;
			send_len <= 3'd0;
			after_send_free <= 1'b0;
			last_sent <= msg_pkg::MSG_CMD_DONE;
			for (int i = 0; i < 5; i++) send_buf[i] <= 8'h00;
		end else if (hr_s2) begin
			send_busy <= 1'b0;
			send_cnt <= 3'd0;
		end else if (send_busy) begin
			if (MSG_IN_READY_IN) begin
				last_sent <= send_buf[send_cnt];
				send_cnt <= (send_cnt == send_len - 3'd1) ? 3'd0 : send_cnt + 3'd1; // idle at slot 0
				if (send_cnt == send_len - 3'd1) send_busy <= 1'b0;
			end
		end else if (got_bad || ext_bad) begin
			// RQ12 RQ14 reject before more message bytes
			send_buf[0] <= msg_pkg::MSG_REJECT;
			send_len <= 3'd1;
			send_busy <= 1'b1;
			after_send_free <= 1'b0;
		end else if (ext_fin) begin
			// answer of an initiator-started exchange
			send_buf[0] <= msg_pkg::MSG_EXTENDED;
			send_buf[1] <= msg_pkg::EXT_LEN;
			send_buf[2] <= msg_pkg::EXT_SYNC_CODE;
			send_buf[3] <= ans_period;
			send_buf[4] <= {4'h0, ans_offset};
			send_len <= 3'd5;
			send_busy <= 1'b1;
			after_send_free <= 1'b0;
		end else if (rx) begin // byte taken now: core requests wait a cycle
			send_busy <= 1'b0;
		end else if (REQ_NEGOTIATE_IN && SEL_BOTH_IDS_IN) begin
			// RQ2 RQ6 own request, fastest period, full offset
			send_buf[0] <= msg_pkg::MSG_EXTENDED;
			send_buf[1] <= msg_pkg::EXT_LEN;
			send_buf[2] <= msg_pkg::EXT_SYNC_CODE;
			send_buf[3] <= msg_pkg::MIN_PERIOD;
			send_buf[4] <= {4'h0, msg_pkg::MAX_OFFSET};
			send_len <= 3'd5;
			send_busy <= 1'b1;
			after_send_free <= 1'b0;
		end else if (REQ_SAVE_DISC_IN && DISC_ALLOWED_OUT) begin
			// RQ7 RQ8 save pointer then disconnect, then free
			send_buf[0] <= msg_pkg::MSG_SAVE_PTR;
			send_buf[1] <= msg_pkg::MSG_DISCONNECT;
			send_len <= 3'd2;
			send_busy <= 1'b1;
			after_send_free <= 1'b1;
		end else if (REQ_DISC_IN && DISC_ALLOWED_OUT) begin
			// RQ8 disconnect announced before busy drops
			send_buf[0] <= msg_pkg::MSG_DISCONNECT;
			send_len <= 3'd1;
			send_busy <= 1'b1;
			after_send_free <= 1'b1;
		end else if (REQ_LINKED_IN) begin
			// RQ18 linked complete code by flag
			send_buf[0] <= LINK_FLAG_IN ? msg_pkg::MSG_LINKED_FLG : msg_pkg::MSG_LINKED;
			send_len <= 3'd1;
			send_busy <= 1'b1;
			after_send_free <= 1'b0;
		end else if (REQ_RECONNECT_IN) begin
			// RQ20 RQ21 identify, lun zero, bit6 clear
			send_buf[0] <= msg_pkg::MSG_IDENTIFY;
			send_len <= 3'd1;
			send_busy <= 1'b1;
			after_send_free <= 1'b0;
		end
	end

	assign MSG_IN_VALID_OUT = send_busy;
	assign MSG_IN_BYTE_OUT = send_buf[send_cnt];
	wire send_done = send_busy && MSG_IN_READY_IN && (send_cnt == send_len - 3'd1);

	//----------------------------------------
	// actions and sense
	//----------------------------------------
	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			BUS_FREE_OUT <= 1'b0;
			CHECK_COND_OUT <= 1'b0;
			CLEAR_OWN_OUT <= 1'b0;
			CLEAR_ALL_OUT <= 1'b0;
			REJECTED_OUT <= 1'b0;
			DISC_ALLOWED_OUT <= 1'b0;
			SENSE_KEY_OUT <= 4'h0;
			SENSE_CODE_OUT <= 8'h00;
		end else begin
			// RQ11 RQ19 abort and device reset go bus free
			BUS_FREE_OUT <= got_abort || got_bdr || (send_done && after_send_free);
			CLEAR_OWN_OUT <= got_abort;
			CLEAR_ALL_OUT <= clr_all;
			// RQ12 initiator refused our last message
			REJECTED_OUT <= got_reject;
			// RQ10 initiator error ends with check condition
			CHECK_COND_OUT <= got_ierr || got_parity
				|| (got_reject && last_sent == msg_pkg::MSG_REJECT);
			if (got_ierr) begin
				SENSE_KEY_OUT <= msg_pkg::SK_ABORTED;
				SENSE_CODE_OUT <= msg_pkg::ASC_INIT_ERR;
			end else if (got_parity) begin
				SENSE_KEY_OUT <= msg_pkg::SK_ABORTED;
				SENSE_CODE_OUT <= msg_pkg::ASC_PARITY;
			end else if (got_reject && last_sent == msg_pkg::MSG_REJECT) begin
				SENSE_KEY_OUT <= msg_pkg::SK_ABORTED;
				SENSE_CODE_OUT <= msg_pkg::ASC_REJECT;
			end
			if (clr_all) DISC_ALLOWED_OUT <= 1'b0;
			else if (got_ident) DISC_ALLOWED_OUT <= b[msg_pkg::ID_DISC_BIT];
		end
	end

	//----------------------------------------
	// checks
	//----------------------------------------
	property p_rate;
		@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		(SYNC_PERIOD_OUT > 8'hFA) |-> (RATE_SEL_OUT == 3'd7);
	endproperty
	a_rate: assert property (p_rate) else $error("bad rate band"); // RQ1
	property p_off;
		@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		SYNC_OFFSET_OUT <= 4'h8;
	endproperty
	a_off: assert property (p_off) else $error("offset above max"); // RQ24
	property p_bdr;
		@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		got_bdr |-> ##1 BUS_FREE_OUT ##1 (SYNC_OFFSET_OUT == 4'h0);
	endproperty
	a_bdr: assert property (p_bdr) else $error("device reset not async"); // RQ19
	property p_abort;
		@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		got_abort |=> (BUS_FREE_OUT && CLEAR_OWN_OUT && !MSG_IN_VALID_OUT);
	endproperty
	a_abort: assert property (p_abort) else $error("abort mishandled"); // RQ11
	property p_rej;
		@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		(got_bad && !send_busy) |=> (MSG_IN_VALID_OUT && MSG_IN_BYTE_OUT == 8'h07);
	endproperty
	a_rej: assert property (p_rej) else $error("reject not sent"); // RQ14
	property p_ierr;
		@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		got_ierr |=> (CHECK_COND_OUT && SENSE_KEY_OUT == 4'hB);
	endproperty
	a_ierr: assert property (p_ierr) else $error("init error not checked"); // RQ10
	property p_nop;
		@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		got_nop |=> !(BUS_FREE_OUT || CHECK_COND_OUT || MSG_IN_VALID_OUT);
	endproperty
	a_nop: assert property (p_nop) else $error("nop acted"); // RQ16
	property p_disc;
		@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		$rose(BUS_FREE_OUT) && !$past(got_abort) && !$past(got_bdr)
			|-> ($past(last_sent) == 8'h04 || last_sent == 8'h04);
	endproperty
	a_disc: assert property (p_disc) else $error("free without disconnect"); // RQ8
endmodule // scsi_msg_handler
`default_nettype wire

/* File: sync_table.sv */
// per-initiator store of agreed period and offset
`timescale 1ns/1ps
`default_nettype none
module sync_table #(
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic          clk_in,
	input  wire logic          resetn_in,
	input  wire logic          clear_in,
	input  wire logic          wr_in,
	input  wire logic [AW-1:0] waddr_in,
	input  wire logic [11:0]   wdata_in,
	input  wire logic [AW-1:0] raddr_in,
	output logic      [11:0]   rdata_out
);
	logic [11:0] mem [DEPTH];

	// entries cleared to asynchronous on any reset event
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < DEPTH; i++) mem[i] <= 12'h000;
			rdata_out <= 12'h000;
		end else begin
			if (clear_in) begin
				for (int i = 0; i < DEPTH; i++) mem[i] <= 12'h000;
			end else if (wr_in) begin
				mem[waddr_in] <= wdata_in;
			end
			rdata_out <= clear_in ? 12'h000 : mem[raddr_in];
		end
	end
endmodule // sync_table
`default_nettype wire

/* File: tb.sv */
// self-checking bench of the target message handler
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic       clk = 1'b0, rst_n = 1'b0, hard_rst = 1'b0, sel_both = 1'b1;
	logic [2:0] init_id = 3'h0;
	logic       out_v = 1'b0;
	logic [7:0] out_b = 8'h00;
	logic [4:0] req = 5'h00;
	logic       flag = 1'b0;
	logic [3:0] slow = 4'h0;
	logic       in_v, in_rdy, free, cc, clr_own, clr_all, disc_ok, rejd, took;
	logic [7:0] in_b, code, period, mb, lf = 8'h1D;
	logic [3:0] key, offset;
	logic [2:0] rate;
	logic [7:0] got[$], none[$];
	int         failures = 0, n_checks = 0, n_free = 0;
	int         exp_p[8], exp_o[8];
	int         bounds[16] = '{0, 62, 63, 93, 94, 125, 126, 156, 157, 187, 188, 218,
		219, 250, 251, 255};

	// ----------------------------------------
	// clock, design, partner
	// ----------------------------------------
	always #50 clk = ~clk;
	scsi_msg_handler dut_u (.CLK_SYS_IN(clk), .RESETN_IN(rst_n), .HARD_RESET_IN(hard_rst),
		.SEL_BOTH_IDS_IN(sel_both), .INIT_ID_IN(init_id), .MSG_OUT_VALID_IN(out_v),
		.MSG_OUT_BYTE_IN(out_b), .REQ_SAVE_DISC_IN(req[0]), .REQ_DISC_IN(req[1]),
		.REQ_LINKED_IN(req[2]), .LINK_FLAG_IN(flag), .REQ_RECONNECT_IN(req[3]),
		.REQ_NEGOTIATE_IN(req[4]), .MSG_IN_READY_IN(in_rdy), .MSG_IN_VALID_OUT(in_v),
		.MSG_IN_BYTE_OUT(in_b), .BUS_FREE_OUT(free), .CHECK_COND_OUT(cc),
		.SENSE_KEY_OUT(key), .SENSE_CODE_OUT(code), .CLEAR_OWN_OUT(clr_own),
		.CLEAR_ALL_OUT(clr_all), .DISC_ALLOWED_OUT(disc_ok), .REJECTED_OUT(rejd),
		.RATE_SEL_OUT(rate), .SYNC_PERIOD_OUT(period), .SYNC_OFFSET_OUT(offset));
	init_model peer_u (.clk_in(clk), .valid_in(in_v), .byte_in(in_b), .delay_in(slow),
		.ready_out(in_rdy), .took_out(took), .byte_out(mb));
	// bench counts bus releases
	// collect what the initiator received and count bus releases
	always @(posedge clk) begin
		if (took === 1'b1) got.push_back(mb);
		if (free === 1'b1) n_free++;
	end

	// ----------------------------------------
	// helpers and reference model
	// ----------------------------------------
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// one message-out byte; pulses are sampled right after it is taken;
	// more keeps the strobe up when another byte follows at once
	task automatic put(input logic [7:0] b, input bit more = 1'b0);
		out_v = 1'b1;
		out_b = b;
		tick(1);
		if (!more) out_v = 1'b0;
	endtask
	// bounded wait for the expected message-in bytes, then compare them all
	task automatic want(input logic [7:0] e[$]);
		int i;
		i = 0;
		while (got.size() < e.size() && i < 300) begin
			tick(1);
			i++;
		end
		tick(3);
		chk("msg in count", 16'(got.size()), 16'(e.size()));
		foreach (e[k]) if (k < got.size()) chk("msg in byte", {8'h00, got[k]}, {8'h00, e[k]});
		got.delete();
	endtask
	function automatic int band(input int p);
		int lim[7] = '{62, 93, 125, 156, 187, 218, 250};
		band = 7;
		for (int k = 6; k >= 0; k--) if (p <= lim[k]) band = k;
	endfunction
	// next value of the stimulus shift register
	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	// negotiation started by the initiator; reply is clipped to our limits
	task automatic nego(input logic [2:0] id, input int p, input int o);
		logic [7:0] e[$];
		init_id = id;
		exp_p[id] = (p < 62) ? 62 : p;
		exp_o[id] = (o > 8) ? 8 : o;
		e = '{8'h01, 8'h03, 8'h01, 8'(exp_p[id]), 8'(exp_o[id])};
		foreach (e[k]) put((k == 3) ? 8'(p) : (k == 4) ? 8'(o) : e[k], k < 4);
		want(e);
		tick(2);
		chk("period", {8'h00, period}, 16'(exp_p[id]));
		chk("offset", {12'h000, offset}, 16'(exp_o[id]));
		chk("rate", {13'h0000, rate}, 16'(band(exp_p[id])));
	endtask
	task automatic table_chk;
		for (int id = 0; id < 8; id++) begin
			init_id = 3'(id);
			tick(2);
			chk("kept period", {8'h00, period}, 16'(exp_p[id]));
			chk("kept offset", {12'h000, offset}, 16'(exp_o[id]));
		end
	endtask
	// a core request answered by the given bytes and bus releases
	task automatic core(input int r, input logic [7:0] e[$], input int frees);
		int i;
		int f0;
		i = 0;
		f0 = n_free;
		req[r] = 1'b1;
		while (in_v !== 1'b1 && i < 50) begin
			tick(1);
			i++;
		end
		req[r] = 1'b0;
		want(e);
		chk("bus free count", 16'(n_free - f0), 16'(frees));
	endtask
	task automatic print_verdict;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
		for (int k = 0; k < 8; k++) exp_p[k] = 0;
		for (int k = 0; k < 8; k++) exp_o[k] = 0;
		tick(1);
		chk("idle outputs", 16'({in_v, free, cc, clr_own, clr_all, rejd, disc_ok}), 16'h0000);
		table_chk();
		put(8'hC0);
		tick(1);
		chk("disc allowed", {15'h0000, disc_ok}, 16'h0001);
		foreach (bounds[k]) if (k < 3) begin
			put(8'h88 >> k);
			want('{8'h07});
		end
		put(8'h06, 1'b1);
		chk("abort", 16'({free, clr_own, clr_all, cc}), 16'h000C);
		put(8'h0C, 1'b1);
		chk("device reset", 16'({free, clr_own, clr_all}), 16'h0005);
		put(8'h05, 1'b1);
		chk("init error", 16'({cc, key, code}), 16'({1'b1, 4'hB, msg_pkg::ASC_INIT_ERR}));
		put(8'h09, 1'b1);
		chk("parity", 16'({cc, key, code}), 16'({1'b1, 4'hB, msg_pkg::ASC_PARITY}));
		put(8'h08);
		chk("no operation", 16'({free, cc, clr_own, clr_all, rejd}), 16'h0000);
		want(none);
		// refused codes, then our reject refused
		foreach (bounds[k]) if (k < 4) begin
			put((k == 3) ? 8'h7F : (k == 2) ? 8'h0D : 8'(k * 3));
			want('{8'h07});
		end
		put(8'h07);
		chk("reject taken", 16'({rejd, cc, code}), 16'({2'b11, msg_pkg::ASC_REJECT}));
		// messages the target starts, prompt and stalled
		for (int s = 0; s < 2; s++) begin
			slow = 4'(s * 3);
			put(8'hC0);
			core(0, '{8'h02, 8'h04}, 1);
			put(8'hC0);
			core(1, '{8'h04}, 1);
			flag = 1'(s);
			core(2, '{8'h0A + 8'(s)}, 0);
			core(3, '{8'h80}, 0);
			core(4, '{8'h01, 8'h03, 8'h01, 8'h3E, 8'h08}, 0);
		end
		// every rate band, few exchanges per initiator
		foreach (bounds[k]) begin
			lf = lfsr_next(lf);
			nego(3'(k), bounds[k], int'(lf[3:0]) + 1);
		end
		nego(3'h2, int'(lf), 0);
		table_chk();
		sel_both = 1'b0;
		put(8'h01, 1'b1);
		put(8'h03, 1'b1);
		put(8'h01);
		want('{8'h07});
		sel_both = 1'b1;
		// bus reset and device reset drop every agreement
		hard_rst = 1'b1;
		tick(4);
		hard_rst = 1'b0;
		tick(4);
		for (int k = 0; k < 8; k++) exp_p[k] = 0;
		for (int k = 0; k < 8; k++) exp_o[k] = 0;
		table_chk();
		nego(3'h5, 100, 4);
		put(8'h0C);
		exp_p[5] = 0;
		exp_o[5] = 0;
		table_chk();
		print_verdict();
	end
	// watchdog well past the expected run length
	initial begin
		#3000000;
		failures++;
		print_verdict();
	end
endmodule // tb
`default_nettype wire
